//--- design/mff_top.sv
`timescale 1ns/10ps
module mff_top #(
  parameter logic [15:0] IMPL_SUBSETS = mff_pkg::MFF_IMPL_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire mff_pkg::mff_axil_req_type axil_req,
  output mff_pkg::mff_axil_rsp_type axil_rsp,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] mff_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Widens the byte strobes into a bit mask.
  function automatic logic [31:0] mff_lanes(input logic [3:0] strb);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = {8{strb[i]}};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Identification helpers
  // ----------------------------------------------------------------
  // Builds the answer of the standard leaf.
  function automatic mff_pkg::mff_ident_type mff_leaf_std();
    mff_pkg::mff_ident_type r;
    r = '0;
    r.edx[mff_pkg::MFF_EDX_FLOAT] = IMPL_SUBSETS[mff_pkg::MFF_SUB_X87]; // RULE_05
    r.edx[mff_pkg::MFF_EDX_LSAVE] = IMPL_SUBSETS[mff_pkg::MFF_SUB_LSAVE]; // RULE_06
    r.edx[mff_pkg::MFF_EDX_SSE1] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE1]; // RULE_02
    r.edx[mff_pkg::MFF_EDX_SSE2] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE2]; // RULE_02
    r.ecx[mff_pkg::MFF_ECX_SSE3] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE3]; // RULE_02
    r.ecx[mff_pkg::MFF_ECX_SSSE3] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSSE3]; // RULE_02
    r.ecx[mff_pkg::MFF_ECX_SSE41] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE41]; // RULE_02
    r.ecx[mff_pkg::MFF_ECX_SSE42] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE42]; // RULE_02
    r.ecx[mff_pkg::MFF_ECX_AVX] = IMPL_SUBSETS[mff_pkg::MFF_SUB_AVX]; // RULE_04
    r.ecx[mff_pkg::MFF_ECX_FMA] = IMPL_SUBSETS[mff_pkg::MFF_SUB_FMA]; // RULE_04
    r.ecx[mff_pkg::MFF_ECX_XSTATE] = IMPL_SUBSETS[mff_pkg::MFF_SUB_XSTATE]; // RULE_08
    return r;
  endfunction

  // Builds the answer of the extended leaf.
  function automatic mff_pkg::mff_ident_type mff_leaf_ext();
    mff_pkg::mff_ident_type r;
    r = '0;
    r.edx[mff_pkg::MFF_EDX_FLOAT] = IMPL_SUBSETS[mff_pkg::MFF_SUB_X87]; // RULE_05
    r.edx[mff_pkg::MFF_EDX_LSAVE] = IMPL_SUBSETS[mff_pkg::MFF_SUB_LSAVE]; // RULE_06
    r.edx[mff_pkg::MFF_EDX_FAST] = IMPL_SUBSETS[mff_pkg::MFF_SUB_FAST]; // RULE_07
    r.ecx[mff_pkg::MFF_ECX_SSE4A] = IMPL_SUBSETS[mff_pkg::MFF_SUB_SSE4A]; // RULE_03
    r.ecx[mff_pkg::MFF_ECX_XOP] = IMPL_SUBSETS[mff_pkg::MFF_SUB_XOP]; // RULE_04
    r.ecx[mff_pkg::MFF_ECX_FMA4] = IMPL_SUBSETS[mff_pkg::MFF_SUB_FMA4]; // RULE_04
    return r;
  endfunction

  // Builds the answer of the extended-state leaf for the optimized-save sub-function.
  function automatic mff_pkg::mff_ident_type mff_leaf_xst();
    mff_pkg::mff_ident_type r;
    r = '0;
    r.eax[mff_pkg::MFF_EAX_OPT] = IMPL_SUBSETS[mff_pkg::MFF_SUB_OPT]; // RULE_08
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Fixed answers
  // ----------------------------------------------------------------
  // The answers hang only on the build parameter, so repeated queries of a leaf agree.
  localparam mff_pkg::mff_ident_type ANS_STD = mff_leaf_std(); // RULE_11
  localparam mff_pkg::mff_ident_type ANS_EXT = mff_leaf_ext(); // RULE_11
  localparam mff_pkg::mff_ident_type ANS_XST = mff_leaf_xst(); // RULE_11

  // Picks the fixed answer of one identification query.
  function automatic mff_pkg::mff_ident_type mff_ident(
    input logic [31:0] fn,
    input logic [31:0] sub
  );
    mff_pkg::mff_ident_type r;
    r = '0;
    if (fn == mff_pkg::MFF_FN_STD) begin
      r = ANS_STD;
    end else if (fn == mff_pkg::MFF_FN_EXT) begin
      r = ANS_EXT;
    end else if (fn == mff_pkg::MFF_FN_XST && sub == mff_pkg::MFF_XST_SUB_OPT) begin
      r = ANS_XST;
    end
    return r;
  endfunction

  // Tells whether a subset belongs to the legacy SIMD class.
  function automatic logic mff_is_legacy(input mff_pkg::mff_subset_type s);
    logic r;
    r = 1'b0;
    unique case (s)
      mff_pkg::MFF_SUB_SSE1, mff_pkg::MFF_SUB_SSE2, mff_pkg::MFF_SUB_SSE3,
      mff_pkg::MFF_SUB_SSSE3, mff_pkg::MFF_SUB_SSE41, mff_pkg::MFF_SUB_SSE42,
      mff_pkg::MFF_SUB_SSE4A: begin
        r = 1'b1;
      end
      mff_pkg::MFF_SUB_AVX, mff_pkg::MFF_SUB_FMA, mff_pkg::MFF_SUB_XOP,
      mff_pkg::MFF_SUB_FMA4, mff_pkg::MFF_SUB_X87, mff_pkg::MFF_SUB_LSAVE,
      mff_pkg::MFF_SUB_FAST, mff_pkg::MFF_SUB_XSTATE, mff_pkg::MFF_SUB_OPT: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Register helpers
  // ----------------------------------------------------------------
  // Returns the word that a read of one offset shows.
  function automatic logic [31:0] mff_read(
    input mff_pkg::mff_state_type s,
    input logic [31:0] addr
  );
    logic [31:0] r;
    r = '0;
    case (addr)
      mff_pkg::MFF_OFF_CTRL: begin
        r[1:0] = s.ctrl;
      end
      mff_pkg::MFF_OFF_FUNC: begin
        r = s.func;
      end
      mff_pkg::MFF_OFF_SUBFN: begin
        r = s.subfn;
      end
      mff_pkg::MFF_OFF_DECODE: begin
        r[10:0] = s.dec;
      end
      mff_pkg::MFF_OFF_EAX: begin
        r = s.res.eax;
      end
      mff_pkg::MFF_OFF_ECX: begin
        r = s.res.ecx;
      end
      mff_pkg::MFF_OFF_EDX: begin
        r = s.res.edx;
      end
      mff_pkg::MFF_OFF_STAT: begin
        r[2:0] = s.stat;
      end
      mff_pkg::MFF_OFF_MASK: begin
        r[2:0] = s.mask;
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // Tells whether an offset is mapped.
  function automatic logic mff_mapped(input logic [31:0] addr);
    logic r;
    r = 1'b0;
    case (addr)
      mff_pkg::MFF_OFF_CTRL, mff_pkg::MFF_OFF_FUNC, mff_pkg::MFF_OFF_SUBFN,
      mff_pkg::MFF_OFF_CMD, mff_pkg::MFF_OFF_DECODE, mff_pkg::MFF_OFF_EAX,
      mff_pkg::MFF_OFF_ECX, mff_pkg::MFF_OFF_EDX, mff_pkg::MFF_OFF_STAT,
      mff_pkg::MFF_OFF_MASK: begin
        r = 1'b1;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Picks the response code for an offset.
  function automatic logic [1:0] mff_resp(input logic [31:0] addr);
    logic [1:0] r;
    r = mff_pkg::MFF_RESP_SLVERR;
    if (mff_mapped(addr)) begin
      r = mff_pkg::MFF_RESP_OKAY;
    end
    return r;
  endfunction

  // Clears the status bits that a write marks with ones.
  function automatic logic [2:0] mff_clear(
    input logic [2:0] stat,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] lanes;
    lanes = mff_lanes(strb);
    return stat & ~(data[2:0] & lanes[2:0]);
  endfunction

  // Judges one executed instruction against the implemented subsets and the control bits.
  function automatic logic [10:0] mff_decode(
    input logic [3:0] code,
    input logic [1:0] ctrl
  );
    logic [10:0] r;
    logic ud;
    logic nm;
    mff_pkg::mff_subset_type sub;
    sub = mff_pkg::mff_subset_type'(code);
    ud = !IMPL_SUBSETS[sub]; // RULE_09
    if (mff_is_legacy(sub) && (!ctrl[mff_pkg::MFF_CTRL_OS_SIMD]
        || ctrl[mff_pkg::MFF_CTRL_EMUL])) begin
      ud = 1'b1; // RULE_10
    end
    nm = !ud && sub == mff_pkg::MFF_SUB_LSAVE && ctrl[mff_pkg::MFF_CTRL_EMUL];
    r = '0;
    r[3:0] = code;
    r[mff_pkg::MFF_DEC_UD] = ud; // RULE_09
    r[mff_pkg::MFF_DEC_NM] = nm;
    r[mff_pkg::MFF_DEC_DONE] = !ud && !nm;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mff_pkg::mff_state_type q;
  mff_pkg::mff_state_type d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] ev;
    logic do_write;
    logic [31:0] mrg;
    ev = '0;
    do_write = 1'b0;
    mrg = '0;
    d = q;

    // Retire answers that the master has taken.
    if (q.rsp.bvalid && axil_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.rsp.rvalid && axil_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end

    // Capture write address and data in either order.
    if (q.rsp.awready && axil_req.awvalid) begin
      d.aw_have = 1'b1;
      d.aw_addr = axil_req.awaddr;
    end
    if (q.rsp.wready && axil_req.wvalid) begin
      d.w_have = 1'b1;
      d.w_data = axil_req.wdata;
      d.w_strb = axil_req.wstrb;
    end

    // Perform a write once both halves are held.
    do_write = q.aw_have && q.w_have && !q.rsp.bvalid;
    if (do_write) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = mff_resp(q.aw_addr);
      case (q.aw_addr)
        mff_pkg::MFF_OFF_CTRL: begin
          mrg = mff_merge({30'h0, q.ctrl}, q.w_data, q.w_strb);
          d.ctrl = mrg[1:0];
        end
        mff_pkg::MFF_OFF_FUNC: begin
          d.func = mff_merge(q.func, q.w_data, q.w_strb);
        end
        mff_pkg::MFF_OFF_SUBFN: begin
          d.subfn = mff_merge(q.subfn, q.w_data, q.w_strb);
        end
        mff_pkg::MFF_OFF_CMD: begin
          if (q.w_strb[0] && q.w_data[mff_pkg::MFF_CMD_EXEC]) begin
            d.res = mff_ident(q.func, q.subfn); // RULE_01 RULE_11
            ev[mff_pkg::MFF_STAT_IDENT] = 1'b1;
          end
        end
        mff_pkg::MFF_OFF_DECODE: begin
          if (q.w_strb[0]) begin
            d.dec = mff_decode(q.w_data[3:0], q.ctrl); // RULE_09 RULE_10
            ev[mff_pkg::MFF_STAT_UD] = d.dec[mff_pkg::MFF_DEC_UD];
            ev[mff_pkg::MFF_STAT_NM] = d.dec[mff_pkg::MFF_DEC_NM];
          end
        end
        mff_pkg::MFF_OFF_STAT: begin
          d.stat = mff_clear(q.stat, q.w_data, q.w_strb);
        end
        mff_pkg::MFF_OFF_MASK: begin
          mrg = mff_merge({29'h0, q.mask}, q.w_data, q.w_strb);
          d.mask = mrg[2:0];
        end
        default: begin
          d.func = q.func;
        end
      endcase
    end

    // Serve a read in the cycle after its address is taken.
    if (q.rsp.arready && axil_req.arvalid) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = mff_read(q, axil_req.araddr);
      d.rsp.rresp = mff_resp(axil_req.araddr);
    end

    // Events set after clears so that a set wins.
    d.stat = d.stat | ev;
    d.rsp.awready = !d.aw_have;
    d.rsp.wready = !d.w_have;
    d.rsp.arready = !d.rsp.rvalid;
    d.irq = |(d.stat & d.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= mff_pkg::MFF_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign axil_rsp = q.rsp;
  assign irq = q.irq;

endmodule

//--- pkg/mff_pkg.sv
// Function
// RULE_01 - Each returned feature bit is one when its subset is implemented and zero otherwise.
// RULE_02 - Leaf 0000_0001h gives SSE1/SSE2 in EDX 25/26 and SSE3/SSSE3/4.1/4.2 in ECX 0/9/19/20.
// RULE_03 - Leaf 8000_0001h reports the SSE4A subset in ECX bit 6.
// RULE_04 - AVX is ECX 28 and FMA ECX 12 of leaf 1; XOP is ECX 11 and FMA4 ECX 16 of 8000_0001h.
// RULE_05 - The x87 unit is reported in EDX bit 0 of both the standard and extended leaf.
// RULE_06 - Legacy state save and restore is reported in EDX bit 24 of both leaves.
// RULE_07 - Fast legacy state save and restore is reported in EDX bit 25 of leaf 8000_0001h.
// RULE_08 - Extended state save is ECX 26 of leaf 1; optimized save is EAX 0 of leaf 0Dh sub 01h.
// RULE_09 - An instruction of an unimplemented subset raises invalid-opcode instead of executing.
// RULE_10 - Legacy SIMD raises invalid-opcode when OS SIMD support is clear or emulation is set.
// RULE_11 - The feature bits are fixed per implementation and never change between queries.
package mff_pkg;

  // ----------------------------------------------------------------
  // Identification leaves and result bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] MFF_FN_STD = 32'h0000_0001;
  localparam logic [31:0] MFF_FN_EXT = 32'h8000_0001;
  localparam logic [31:0] MFF_FN_XST = 32'h0000_000d;
  localparam logic [31:0] MFF_XST_SUB_OPT = 32'h0000_0001;
  localparam int MFF_EDX_FLOAT = 0;
  localparam int MFF_EDX_LSAVE = 24;
  localparam int MFF_EDX_SSE1 = 25;
  localparam int MFF_EDX_SSE2 = 26;
  localparam int MFF_EDX_FAST = 25;
  localparam int MFF_ECX_SSE3 = 0;
  localparam int MFF_ECX_SSSE3 = 9;
  localparam int MFF_ECX_SSE41 = 19;
  localparam int MFF_ECX_SSE42 = 20;
  localparam int MFF_ECX_FMA = 12;
  localparam int MFF_ECX_XSTATE = 26;
  localparam int MFF_ECX_AVX = 28;
  localparam int MFF_ECX_SSE4A = 6;
  localparam int MFF_ECX_XOP = 11;
  localparam int MFF_ECX_FMA4 = 16;
  localparam int MFF_EAX_OPT = 0;

  // ----------------------------------------------------------------
  // Instruction subsets
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MFF_SUB_SSE1 = 4'h0, MFF_SUB_SSE2 = 4'h1, MFF_SUB_SSE3 = 4'h2, MFF_SUB_SSSE3 = 4'h3,
    MFF_SUB_SSE41 = 4'h4, MFF_SUB_SSE42 = 4'h5, MFF_SUB_SSE4A = 4'h6, MFF_SUB_AVX = 4'h7,
    MFF_SUB_FMA = 4'h8, MFF_SUB_XOP = 4'h9, MFF_SUB_FMA4 = 4'ha, MFF_SUB_X87 = 4'hb,
    MFF_SUB_LSAVE = 4'hc, MFF_SUB_FAST = 4'hd, MFF_SUB_XSTATE = 4'he, MFF_SUB_OPT = 4'hf
  } mff_subset_type;
  localparam logic [15:0] MFF_IMPL_DEFAULT = 16'hffff;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [31:0] MFF_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] MFF_OFF_FUNC = 32'h0000_0004;
  localparam logic [31:0] MFF_OFF_SUBFN = 32'h0000_0008;
  localparam logic [31:0] MFF_OFF_CMD = 32'h0000_000c;
  localparam logic [31:0] MFF_OFF_DECODE = 32'h0000_0010;
  localparam logic [31:0] MFF_OFF_EAX = 32'h0000_0014;
  localparam logic [31:0] MFF_OFF_ECX = 32'h0000_0018;
  localparam logic [31:0] MFF_OFF_EDX = 32'h0000_001c;
  localparam logic [31:0] MFF_OFF_STAT = 32'h0000_0020;
  localparam logic [31:0] MFF_OFF_MASK = 32'h0000_0024;
  localparam int MFF_CTRL_OS_SIMD = 0;
  localparam int MFF_CTRL_EMUL = 1;
  localparam int MFF_CMD_EXEC = 0;
  localparam int MFF_DEC_UD = 8;
  localparam int MFF_DEC_NM = 9;
  localparam int MFF_DEC_DONE = 10;
  localparam int MFF_STAT_IDENT = 0;
  localparam int MFF_STAT_UD = 1;
  localparam int MFF_STAT_NM = 2;
  localparam logic [1:0] MFF_RESP_OKAY = 2'h0;
  localparam logic [1:0] MFF_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [31:0] araddr; logic rready;
  } mff_axil_req_type;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } mff_axil_rsp_type;
  typedef struct packed {
    logic [31:0] eax; logic [31:0] ecx; logic [31:0] edx;
  } mff_ident_type;
  typedef struct packed {
    logic aw_have; logic [31:0] aw_addr; logic w_have; logic [31:0] w_data; logic [3:0] w_strb;
    mff_axil_rsp_type rsp; logic [1:0] ctrl; logic [31:0] func; logic [31:0] subfn;
    mff_ident_type res; logic [10:0] dec; logic [2:0] stat; logic [2:0] mask; logic irq;
  } mff_state_type;
  localparam mff_state_type MFF_STATE_RESET = '0;

endpackage

//--- tb/media_feature_flags_test.sv
`timescale 1ns/10ps
module media_feature_flags_test;
  // ------------------------------------------------------------
  // Bench signals and bus tasks.
  // ------------------------------------------------------------
  localparam logic [15:0] IM = 16'hda7f;
  logic mclk;
  logic rst;
  logic irq;
  mff_pkg::mff_axil_req_type rq;
  mff_pkg::mff_axil_rsp_type rs;
  logic [31:0] rd;
  logic [1:0] rr;
  int errors;
  int n_compared;
  mff_top #(.IMPL_SUBSETS(IM)) u_mff_top (.mclk(mclk), .rst(rst), .axil_req(rq),
    .axil_rsp(rs), .irq(irq));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    rq <= '{awvalid:1'h1, awaddr:a, wvalid:1'h1, wdata:d, wstrb:4'hf, bready:1'h1, default:'0};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (rs.awready) rq.awvalid <= 1'h0;
      if (rs.wready) rq.wvalid <= 1'h0;
    end while (!rs.bvalid && n < 100);
    rr = rs.bresp;
    chk("write answer", {31'h0, rs.bvalid}, 32'h1);
    rq.bready <= 1'h0;
  endtask
  task automatic rdw(input logic [31:0] a);
    int n;
    @(posedge mclk);
    rq <= '{arvalid:1'h1, araddr:a, rready:1'h1, default:'0};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (rs.arready) rq.arvalid <= 1'h0;
    end while (!rs.rvalid && n < 100);
    rd = rs.rdata;
    rr = rs.rresp;
    chk("read answer", {31'h0, rs.rvalid}, 32'h1);
    rq.rready <= 1'h0;
  endtask
  task automatic ick(input string nm, input logic e);
    @(posedge mclk);
    chk(nm, {31'h0, irq}, {31'h0, e});
  endtask
  function automatic logic [95:0] feat(input logic [31:0] f, input logic [31:0] s);
    feat = '0;
    if (f == mff_pkg::MFF_FN_STD) begin
      feat[63:32] = {3'h0, IM[7], 1'h0, IM[14], 5'h0, IM[5], IM[4], 6'h0, IM[8], 2'h0, IM[3],
        8'h0, IM[2]};
      feat[31:0] = {5'h0, IM[1], IM[0], IM[12], 23'h0, IM[11]};
    end
    if (f == mff_pkg::MFF_FN_EXT) begin
      feat[63:32] = {15'h0, IM[10], 4'h0, IM[9], 4'h0, IM[6], 6'h0};
      feat[31:0] = {6'h0, IM[13], IM[12], 23'h0, IM[11]};
    end
    if (f == mff_pkg::MFF_FN_XST && s == 32'h1) feat[64] = IM[15];
  endfunction
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 10; i++) begin
      rdw(32'(i * 4));
      chk("reset value", rd, 32'h0);
      chk("read resp", {30'h0, rr}, {30'h0, mff_pkg::MFF_RESP_OKAY});
    end
    ick("irq idle", 1'h0);
    rdw(32'h0000_0040);
    chk("unmapped resp", {30'h0, rr}, {30'h0, mff_pkg::MFF_RESP_SLVERR});
    wr(mff_pkg::MFF_OFF_EDX, 32'hffff_ffff);
    chk("write resp", {30'h0, rr}, {30'h0, mff_pkg::MFF_RESP_OKAY});
    rdw(mff_pkg::MFF_OFF_EDX);
    chk("edx read only", rd, 32'h0);
    wr(32'h0000_0040, 32'h1);
    chk("unmapped write", {30'h0, rr}, {30'h0, mff_pkg::MFF_RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_ident;
    logic [31:0] fl [5];
    logic [31:0] sl [5];
    logic [95:0] e;
    fl = '{mff_pkg::MFF_FN_STD, mff_pkg::MFF_FN_EXT, mff_pkg::MFF_FN_XST,
      mff_pkg::MFF_FN_XST, 32'h2};
    sl = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h1};
    for (int i = 0; i < 5; i++) begin
      wr(mff_pkg::MFF_OFF_FUNC, fl[i]);
      wr(mff_pkg::MFF_OFF_SUBFN, sl[i]);
      e = feat(fl[i], sl[i]);
      for (int k = 0; k < 2; k++) begin
        wr(mff_pkg::MFF_OFF_CMD, 32'h1);
        rdw(mff_pkg::MFF_OFF_EAX);
        chk("eax", rd, e[95:64]);
        rdw(mff_pkg::MFF_OFF_ECX);
        chk("ecx", rd, e[63:32]);
        rdw(mff_pkg::MFF_OFF_EDX);
        chk("edx", rd, e[31:0]);
      end
    end
    $display("test ident done");
  endtask
  task automatic t_decode;
    logic u;
    logic n;
    for (int c = 0; c < 4; c++) begin
      wr(mff_pkg::MFF_OFF_CTRL, 32'(c));
      for (int s = 0; s < 16; s++) begin
        u = !IM[s] || (s < 7 && (c[0] == 1'h0 || c[1] == 1'h1));
        n = !u && s == 12 && c[1] == 1'h1;
        wr(mff_pkg::MFF_OFF_DECODE, 32'(s));
        rdw(mff_pkg::MFF_OFF_DECODE);
        chk("decode", rd, {21'h0, !u && !n, n, u, 4'h0, 4'(s)});
      end
    end
    $display("test decode done");
  endtask
  task automatic t_irq;
    wr(mff_pkg::MFF_OFF_STAT, 32'h7);
    wr(mff_pkg::MFF_OFF_MASK, 32'h0);
    wr(mff_pkg::MFF_OFF_CTRL, 32'h1);
    wr(mff_pkg::MFF_OFF_DECODE, 32'h7);
    ick("irq masked", 1'h0);
    wr(mff_pkg::MFF_OFF_MASK, 32'h2);
    ick("irq raised", 1'h1);
    wr(mff_pkg::MFF_OFF_STAT, 32'h1);
    ick("irq kept", 1'h1);
    wr(mff_pkg::MFF_OFF_STAT, 32'h2);
    ick("irq cleared", 1'h0);
    rdw(mff_pkg::MFF_OFF_STAT);
    chk("status", rd, 32'h0);
    $display("test irq done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    n_compared = 0;
    rst = 1'h1;
    rq = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_reset;
    t_ident;
    t_decode;
    t_irq;
    complete_run;
  end
  initial begin
    #1000000;
    errors++;
    complete_run;
  end
endmodule

//--- tb/mff_properties.sv
`timescale 1ns/10ps
module mff_properties #(
  parameter logic [15:0] IMPL_SUBSETS = mff_pkg::MFF_IMPL_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire mff_pkg::mff_axil_req_type axil_req,
  input wire mff_pkg::mff_axil_rsp_type axil_rsp,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Shadow of the last identification and decode requests.
  // ------------------------------------------------------------
  logic [15:0] m;
  logic [31:0] aw_q, wd_q, fn_q, sb_q, rf_q, rs_q;
  logic [31:0] e1c, e1d, e8c, e8d;
  logic [1:0] ct_q;
  logic bv_q, dv_q, ui_q, lg_q;
  logic rt, ra, rc, rx, rdc, s1, s8, so;
  assign m = IMPL_SUBSETS;
  assign rt = axil_req.arvalid && axil_rsp.arready;
  assign ra = rt && axil_req.araddr == mff_pkg::MFF_OFF_EAX;
  assign rc = rt && axil_req.araddr == mff_pkg::MFF_OFF_ECX;
  assign rx = rt && axil_req.araddr == mff_pkg::MFF_OFF_EDX;
  assign rdc = rt && axil_req.araddr == mff_pkg::MFF_OFF_DECODE;
  assign s1 = rf_q == mff_pkg::MFF_FN_STD;
  assign s8 = rf_q == mff_pkg::MFF_FN_EXT;
  assign so = rf_q == mff_pkg::MFF_FN_XST && rs_q == mff_pkg::MFF_XST_SUB_OPT;
  assign e1d = {5'h0, m[1], m[0], m[12], 23'h0, m[11]};
  assign e8d = {6'h0, m[13], m[12], 23'h0, m[11]};
  assign e1c = {3'h0, m[7], 1'h0, m[14], 5'h0, m[5], m[4], 6'h0, m[8], 2'h0, m[3], 8'h0, m[2]};
  assign e8c = {15'h0, m[10], 4'h0, m[9], 4'h0, m[6], 6'h0};
  always_ff @(posedge mclk) begin
    if (rst) begin
      {aw_q, wd_q, fn_q, sb_q, rf_q, rs_q} <= '0;
      {bv_q, dv_q, ui_q, lg_q, ct_q} <= '0;
    end else begin
      bv_q <= axil_rsp.bvalid;
      if (axil_req.awvalid && axil_rsp.awready) begin
        aw_q <= axil_req.awaddr;
      end
      if (axil_req.wvalid && axil_rsp.wready) begin
        wd_q <= axil_req.wdata;
      end
      if (axil_rsp.bvalid && !bv_q) begin
        case (aw_q)
          mff_pkg::MFF_OFF_FUNC: fn_q <= wd_q;
          mff_pkg::MFF_OFF_SUBFN: sb_q <= wd_q;
          mff_pkg::MFF_OFF_CTRL: ct_q <= wd_q[1:0];
          mff_pkg::MFF_OFF_CMD: begin
            rf_q <= wd_q[0] ? fn_q : rf_q;
            rs_q <= wd_q[0] ? sb_q : rs_q;
          end
          mff_pkg::MFF_OFF_DECODE: begin
            dv_q <= 1'h1;
            ui_q <= !m[wd_q[3:0]];
            lg_q <= wd_q[3:0] < 4'h7 && (!ct_q[0] || ct_q[1]);
          end
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  std_edx_a: assert property (rx && s1 |=> axil_rsp.rdata == e1d)
    else $error("Standard leaf EDX word is wrong.");
  ext_edx_a: assert property (rx && s8 |=> axil_rsp.rdata == e8d)
    else $error("Extended leaf EDX word is wrong.");
  std_ecx_a: assert property (rc && s1 |=> axil_rsp.rdata == e1c)
    else $error("Standard leaf ECX word is wrong.");
  ext_ecx_a: assert property (rc && s8 |=> axil_rsp.rdata == e8c)
    else $error("Extended leaf ECX word is wrong.");
  opt_save_a: assert property (ra && so |=> axil_rsp.rdata == {31'h0, m[15]})
    else $error("Optimized save flag is wrong.");
  other_leaf_a: assert property ((rc || rx) && !s1 && !s8 |-> ##1 axil_rsp.rdata == '0)
    else $error("Unlisted leaf returns set bits.");
  eax_zero_a: assert property (ra && !so |=> axil_rsp.rdata == '0)
    else $error("EAX word is not zero.");
  dec_unimpl_a: assert property (rdc && dv_q && ui_q |=> axil_rsp.rdata[8])
    else $error("Missing subset did not fault.");
  dec_legacy_a: assert property (rdc && dv_q && lg_q |=> axil_rsp.rdata[8])
    else $error("Disabled legacy subset did not fault.");
  dec_allow_a: assert property (rdc && dv_q && !ui_q && !lg_q |=> !axil_rsp.rdata[8])
    else $error("Permitted subset faulted.");
endmodule

bind mff_top mff_properties #(.IMPL_SUBSETS(IMPL_SUBSETS)) u_mff_properties (.mclk(mclk),
  .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp), .irq(irq));
